// >>> design/cive_encoder.sv
// Current input value encoder with APB registers and diagnostic interrupt
//
// How it works
// - Each measurement leaves as one signed 16-bit two's-complement word.
// - Bipolar rated span scales linearly to +27648 and -27648.
// - Bipolar overshoot to 32511, undershoot to -32512, beyond saturates 7FFF/8000.
// - Unipolar rated 0 to 27648, undershoot to -4864, below gives -32768.
// - Twenty mA symmetric: 6C00, 9400, 7EFF at 23.52 mA, 8100 at -23.52.
// - Unipolar: 0 or 4 mA gives zero, 20 mA gives 6C00, floor ED00.
// - Wire break enabled and detected: output 7FFF, raise wire break alarm.
// - Wire break off, limit diagnostic on, open input: 8000 and low-limit alarm.
// - Both diagnostics off, open input: 8000 and no alarm.
// - An error sets a diagnostic bit only when its diagnostic is enabled; interrupt only when its mask enables it.
// - Value left aligned, bits below the resolution forced to zero.
// - Range code 03 means 4 to 20 mA, 04 means symmetric 20 mA.
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`include "cive_regs.svh"
`default_nettype none
module cive_encoder
	import cive_pkg::*;
#(
	parameter int RES_BITS = 16
)
(
	input  wire logic            clk_in,
	input  wire logic            reset_n_in,
	input  wire cive_sample_type sample_in,
	input  wire logic            wire_break_in,
	input  wire logic            psel_in,
	input  wire logic            penable_in,
	input  wire logic            pwrite_in,
	input  wire logic [11:0]     paddr_in,
	input  wire logic [31:0]     pwdata_in,
	output logic [31:0]          prdata_out,
	output logic                 pready_out,
	output logic                 pslverr_out,
	output logic [15:0]          word_out,
	output logic                 word_valid_out,
	output logic                 irq_out
);

	localparam logic [15:0] RES_MASK = 16'(16'hFFFF << (16 - RES_BITS));

	cive_state_type     st;
	cive_state_type     next_st;
	cive_range_type     rng;
	cive_diag_type      diag_set;
	cive_diag_type      diag_clr;
	logic signed [31:0] scaled;
	logic signed [31:0] floor_code;
	logic               open_in;
	logic               wb_act;
	logic               access;
	logic               mapped;
	logic [15:0]        code_word;

	// Range code decoding
	function automatic cive_range_type range_of(input logic [7:0] code);
		case (code)
			`CIVE_RNG_0_20: range_of = CIVE_UNI0;
			`CIVE_RNG_4_20: range_of = CIVE_UNI4;
			`CIVE_RNG_PM20: range_of = CIVE_BIP;
			default:        range_of = CIVE_OFF;
		endcase
	endfunction

	// Known register offsets
	function automatic logic is_mapped(input logic [11:0] addr);
		is_mapped = (addr == `CIVE_ADDR_CTRL) || (addr == `CIVE_ADDR_STATUS) ||
			(addr == `CIVE_ADDR_MASK) || (addr == `CIVE_ADDR_DATA);
	endfunction

	// Interpolating scaler
	cive_scale u_scale
	(
		.current_na_in (sample_in.current_na),
		.range_in      (rng),
		.code_out      (scaled)
	);

	// Decoded control and open input
	assign rng        = range_of(st.ctrl.range_code);
	assign open_in    = st.wb_sync;
	assign wb_act     = open_in && st.ctrl.wb_en;
	assign floor_code = (rng == CIVE_BIP) ? `CIVE_UNS_MIN_BIP : `CIVE_UNS_MIN_UNI;
	assign code_word  = scaled[15:0] & RES_MASK;
	assign access     = psel_in && penable_in;
	assign mapped     = is_mapped(paddr_in);

	// APB answer and interrupt
	assign pready_out     = 1'b1;
	assign pslverr_out    = access && !mapped;
	assign prdata_out     = st.prdata;
	assign word_out       = st.word;
	assign word_valid_out = st.word_valid;
	assign irq_out        = |(st.status & st.mask);

	// Next state
	always_comb
	begin
		next_st         = st;
		diag_set        = '0;
		diag_clr        = '0;
		// Wire break pin through two flip-flops
		next_st.wb_meta = wire_break_in;
		next_st.wb_sync = st.wb_meta;
		next_st.word_valid = sample_in.valid;
		// Band classification and saturation
		if (sample_in.valid)
		begin
			diag_set.ready = 1'b1;
			if (rng == CIVE_OFF)
				next_st.word = `CIVE_CODE_ZERO;
			else if (wb_act)
			begin
				next_st.word = `CIVE_CODE_OVF;
				diag_set.wb  = 1'b1;
			end
			else if (open_in)
			begin
				next_st.word = `CIVE_CODE_UNF;
				diag_set.low = st.ctrl.ovf_en;
			end
			else if (scaled > `CIVE_OVS_MAX)
			begin
				next_st.word  = `CIVE_CODE_OVF;
				diag_set.high = st.ctrl.ovf_en;
			end
			else if (scaled < floor_code)
			begin
				next_st.word = `CIVE_CODE_UNF;
				diag_set.low = st.ctrl.ovf_en;
			end
			else
				next_st.word = code_word;
		end
		// Read data captured in the setup cycle
		if (psel_in && !penable_in)
		begin
			case (paddr_in)
				`CIVE_ADDR_CTRL:   next_st.prdata = 32'(st.ctrl);
				`CIVE_ADDR_STATUS: next_st.prdata = 32'(st.status);
				`CIVE_ADDR_MASK:   next_st.prdata = 32'(st.mask);
				`CIVE_ADDR_DATA:   next_st.prdata = {16'h0000, st.word};
				default:           next_st.prdata = 32'h00000000;
			endcase
		end
		// Register writes in the access cycle
		if (access && pwrite_in)
		begin
			case (paddr_in)
				`CIVE_ADDR_CTRL:   next_st.ctrl = pwdata_in[`CIVE_CTRL_WIDTH-1:0];
				`CIVE_ADDR_STATUS: diag_clr = pwdata_in[`CIVE_ST_WIDTH-1:0];
				`CIVE_ADDR_MASK:   next_st.mask = pwdata_in[`CIVE_ST_WIDTH-1:0];
				default:           next_st.mask = st.mask;
			endcase
		end
		// Sticky status, a new event beats a clear
		next_st.status = (st.status & ~diag_clr) | diag_set;
	end

	// State register
	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			st      <= '0;
			st.ctrl <= `CIVE_CTRL_RST;
		end
		else
			st <= next_st;
	end

	// Checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);

	logic in_band;
	assign in_band = !open_in && (rng == CIVE_BIP) && (scaled <= `CIVE_OVS_MAX) &&
		(scaled >= `CIVE_UNS_MIN_BIP);

	// Word timing, bipolar and unipolar bands
	word_pulse_a: assert property (
		sample_in.valid |=> word_valid_out ##1 (word_valid_out == $past(sample_in.valid)))
		else $error("word valid does not follow sample");

	bip_linear_a: assert property (
		sample_in.valid && in_band |=> word_out == ($past(scaled[15:0]) & RES_MASK))
		else $error("bipolar word not the scaled code");

	bip_sat_a: assert property (
		sample_in.valid && !open_in && rng == CIVE_BIP && scaled > `CIVE_OVS_MAX
		|=> word_out == `CIVE_CODE_OVF && (st.status.high == $past(st.ctrl.ovf_en)
		|| $past(st.status.high)))
		else $error("bipolar overflow not saturated");

	uni_floor_a: assert property (
		sample_in.valid && !open_in && rng != CIVE_BIP && rng != CIVE_OFF &&
		scaled < `CIVE_UNS_MIN_UNI |=> word_out == `CIVE_CODE_UNF)
		else $error("unipolar underflow not saturated");

	pm20_code_a: assert property (
		sample_in.valid && !open_in && rng == CIVE_BIP &&
		sample_in.current_na == 32'shFECED300 |=> word_out == 16'h9400)
		else $error("minus 20 mA not 9400");

	live_zero_a: assert property (
		sample_in.valid && !open_in && rng == CIVE_UNI4 &&
		sample_in.current_na == 32'sh003D0900 |=> word_out == 16'h0000)
		else $error("4 mA not zero");

	// Open input handling
	wb_code_a: assert property (
		sample_in.valid && rng != CIVE_OFF && wb_act |=> word_out == `CIVE_CODE_OVF
		&& st.status.wb ##1 st.status.wb || $past(diag_clr.wb, 1))
		else $error("wire break code or alarm missing");

	open_low_a: assert property (
		sample_in.valid && rng != CIVE_OFF && open_in && !st.ctrl.wb_en && st.ctrl.ovf_en
		|=> word_out == `CIVE_CODE_UNF && st.status.low)
		else $error("open input low alarm missing");

	open_quiet_a: assert property (
		sample_in.valid && rng != CIVE_OFF && open_in && !st.ctrl.wb_en &&
		!st.ctrl.ovf_en |=> word_out == `CIVE_CODE_UNF &&
		((st.status.low && !$past(st.status.low)) == 1'b0))
		else $error("open input raised an alarm");

	// Interrupt and resolution
	irq_gate_a: assert property (
		sample_in.valid && rng != CIVE_OFF && wb_act && st.mask.wb |=> irq_out)
		else $error("enabled diagnostic gave no interrupt");

	low_bits_a: assert property (
		word_valid_out && !$past(open_in) |-> (word_out & ~RES_MASK) == 16'h0000
		|| word_out == `CIVE_CODE_OVF)
		else $error("bits below resolution not zero");

	range_dec_a: assert property (
		$past(access && pwrite_in && paddr_in == `CIVE_ADDR_CTRL &&
		pwdata_in[7:0] == `CIVE_RNG_PM20) |-> rng == CIVE_BIP)
		else $error("range code 04 not decoded");

	// Unipolar overshoot end
	uni_ovf_a: assert property (
		sample_in.valid && !open_in && rng != CIVE_BIP && rng != CIVE_OFF &&
		scaled > `CIVE_OVS_MAX |=> word_out == `CIVE_CODE_OVF)
		else $error("unipolar overflow not saturated");

	// Twenty mA top of the live-zero range
	uni_top_a: assert property (
		sample_in.valid && !open_in && rng == CIVE_UNI4 &&
		sample_in.current_na == 32'sh01312D00 |=> word_out == 16'h6C00)
		else $error("20 mA in live-zero range not 6C00");

	// Bipolar underflow saturation and its alarm
	bip_unf_a: assert property (
		sample_in.valid && !open_in && rng == CIVE_BIP && scaled < `CIVE_UNS_MIN_BIP
		|=> word_out == `CIVE_CODE_UNF && (st.status.low || !$past(st.ctrl.ovf_en)))
		else $error("bipolar underflow not saturated");

	// Plus full scale of the symmetric range
	pm20_top_a: assert property (
		sample_in.valid && !open_in && rng == CIVE_BIP &&
		sample_in.current_na == 32'sh01312D00 |=> word_out == 16'h6C00)
		else $error("plus 20 mA not 6C00");

	// Deactivated range gives a zero word
	off_zero_a: assert property (
		sample_in.valid && rng == CIVE_OFF |=> word_out == `CIVE_CODE_ZERO)
		else $error("deactivated range not zero");

	// Word holds between samples
	word_hold_a: assert property (
		!sample_in.valid |=> $stable(word_out))
		else $error("word changed without a sample");

	// Open input only seen after two flip-flops
	wb_sync_a: assert property (
		$rose(open_in) |-> $past(wire_break_in, 2))
		else $error("wire break seen before synchronising");

	// Every sample sets the ready bit
	ready_bit_a: assert property (
		sample_in.valid |=> st.status.ready)
		else $error("sample did not set the ready bit");

	// Status bits rise only with a sample
	event_only_a: assert property (
		!sample_in.valid |=> (4'(st.status) & ~4'($past(st.status))) == 4'h0)
		else $error("status bit set without a sample");

	// Disabled limit diagnostic stays quiet
	high_quiet_a: assert property (
		sample_in.valid && !open_in && rng != CIVE_OFF && scaled > `CIVE_OVS_MAX &&
		!st.ctrl.ovf_en |=> !st.status.high || $past(st.status.high))
		else $error("disabled limit diagnostic raised an alarm");

	// Low limit bit sticks until cleared
	low_sticky_a: assert property (
		st.status.low && !diag_clr.low |=> st.status.low)
		else $error("low limit bit lost without a clear");

	// No interrupt while every event is masked
	irq_off_a: assert property (
		4'(st.mask) == 4'h0 |-> !irq_out)
		else $error("interrupt raised while masked");

	// Main scenarios reached
	cover_ovf_c:  cover property (sample_in.valid && scaled > `CIVE_OVS_MAX ##1 word_valid_out);
	cover_wb_c:   cover property (sample_in.valid && wb_act ##1 irq_out);
	cover_read_c: cover property (access && !pwrite_in && paddr_in == `CIVE_ADDR_DATA);
	cover_clr_c:  cover property (diag_clr.ready && diag_set.ready);
	cover_uni_c:  cover property (sample_in.valid && rng == CIVE_UNI4 ##1 word_valid_out);

endmodule // cive_encoder
`default_nettype wire

// >>> design/cive_scale.sv
// Straight-line scaling of a current in nA to a signed channel code
`include "cive_regs.svh"
`default_nettype none
module cive_scale
	import cive_pkg::*;
(
	input  wire logic signed [31:0] current_na_in,
	input  wire cive_range_type     range_in,
	output logic signed [31:0]      code_out
);

	logic signed [63:0] span;
	logic signed [63:0] offset;
	logic signed [63:0] delta;
	logic signed [63:0] num;
	logic signed [63:0] quot;

	// Span and zero point of the selected range
	always_comb
	begin
		span   = `CIVE_SPAN_20MA;
		offset = `CIVE_OFS_0MA;
		if (range_in == CIVE_UNI4)
		begin
			span   = `CIVE_SPAN_16MA;
			offset = `CIVE_OFS_4MA;
		end
	end

	// Rounded interpolation, half away from zero
	always_comb
	begin
		delta = 64'(current_na_in) - offset;
		num   = delta * 2 * `CIVE_FS_CODE;
		if (delta < 0)
			num = num - span;
		else
			num = num + span;
		quot  = num / (span * 2);
	end

	// Magnitude stays far below 2**31 for any 32-bit input
	assign code_out = quot[31:0];

endmodule // cive_scale
`default_nettype wire

// >>> pkg/cive_pkg.sv
// Types shared by the current input value encoder
`default_nettype none
package cive_pkg;

	// Kind of measuring range after decoding
	typedef enum logic [1:0] {CIVE_OFF, CIVE_UNI0, CIVE_UNI4, CIVE_BIP} cive_range_type;

	// Converter sample, current in nA
	typedef struct packed {
		logic               valid;
		logic signed [31:0] current_na;
	} cive_sample_type;

	// Control register
	typedef struct packed {
		logic       ovf_en;
		logic       wb_en;
		logic [7:0] range_code;
	} cive_ctrl_type;

	// Diagnostic status and mask layout
	typedef struct packed {
		logic ready;
		logic high;
		logic low;
		logic wb;
	} cive_diag_type;

	// Whole state of the encoder
	typedef struct packed {
		logic          wb_meta;
		logic          wb_sync;
		cive_ctrl_type ctrl;
		cive_diag_type status;
		cive_diag_type mask;
		logic [15:0]   word;
		logic          word_valid;
		logic [31:0]   prdata;
	} cive_state_type;

endpackage
`default_nettype wire

// >>> pkg/cive_regs.svh
// Register offsets, field positions, codes and scaling constants of the current encoder
`ifndef CIVE_REGS_SVH
`define CIVE_REGS_SVH

// Register byte offsets
`define CIVE_ADDR_CTRL    12'h000
`define CIVE_ADDR_STATUS  12'h004
`define CIVE_ADDR_MASK    12'h008
`define CIVE_ADDR_DATA    12'h00C

// Control field layout and reset value
`define CIVE_CTRL_WIDTH   10
`define CIVE_CTRL_RST     10'h000
`define CIVE_CTRL_WB_BIT  8
`define CIVE_CTRL_OVF_BIT 9

// Diagnostic status bits
`define CIVE_ST_WIDTH     4
`define CIVE_ST_WB_BIT    0
`define CIVE_ST_LOW_BIT   1
`define CIVE_ST_HIGH_BIT  2
`define CIVE_ST_RDY_BIT   3

// Measuring range selection codes
`define CIVE_RNG_0_20     8'h02
`define CIVE_RNG_4_20     8'h03
`define CIVE_RNG_PM20     8'h04

// Band limits as signed codes
`define CIVE_FS_CODE      64'sh0000000000006C00
`define CIVE_OVS_MAX      32'sh00007EFF
`define CIVE_UNS_MIN_BIP  32'shFFFF8100
`define CIVE_UNS_MIN_UNI  32'shFFFFED00
`define CIVE_CODE_OVF     16'h7FFF
`define CIVE_CODE_UNF     16'h8000
`define CIVE_CODE_ZERO    16'h0000

// Spans and offsets in nA: 20 mA, 16 mA, 4 mA
`define CIVE_SPAN_20MA    64'sh0000000001312D00
`define CIVE_SPAN_16MA    64'sh0000000000F42400
`define CIVE_OFS_4MA      64'sh00000000003D0900
`define CIVE_OFS_0MA      64'sh0000000000000000

`endif

// >>> sim/cive_reader.sv
// Controller model that captures each channel word
`default_nettype none
module cive_reader
(
	input  wire logic        clk_in,
	input  wire logic        reset_n_in,
	input  wire logic [15:0] word_in,
	input  wire logic        word_valid_in,
	output logic [15:0]      last_word_out,
	output int               n_words_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// Take one whole word on each valid pulse
	always_ff @(posedge clk_in or negedge reset_n_in)
		if (!reset_n_in)
		begin
			last_word_out <= 16'h0000;
			n_words_out <= 0;
		end
		else if (word_valid_in)
		begin
			last_word_out <= word_in;
			n_words_out <= n_words_out + 1;
		end
endmodule // cive_reader
`default_nettype wire

// >>> sim/tb_current_input_value_encoder.sv
// Self-checking testbench of the current input value encoder
`include "cive_regs.svh"
`default_nettype none
module tb_current_input_value_encoder
	import cive_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic            clk = 1'b0;
	logic            rst_n = 1'b0;
	cive_sample_type smp = '0;
	logic            wbrk = 1'b0;
	logic            psel = 1'b0;
	logic            pen = 1'b0;
	logic            pwr = 1'b0;
	logic [11:0]     paddr = 12'h000;
	logic [31:0]     pwdata = 32'h0;
	logic [31:0]     prdata, rd;
	logic            pready, pslverr, wvalid, irq, err;
	logic [15:0]     word, last;
	int              nw, errors = 0, n_compared = 0, cyc = 0;
	// Columns: control, wire break, current in nA, word, status (FF skips)
	int              tv [20][5] = '{
		'{12'h204, 0, 20000000, 16'h6C00, 8'h8},
		'{12'h204, 0, -20000000, 16'h9400, 8'h8},
		'{12'h204, 0, 723, 16'h0001, 8'h8},
		'{12'h204, 0, -15000000, 16'hAF00, 8'h8},
		'{12'h204, 0, 23517795, 16'h7EFF, 8'h8},
		'{12'h204, 0, 23518800, 16'h7FFF, 8'hC},
		'{12'h204, 0, -23518518, 16'h8100, 8'h8},
		'{12'h204, 0, -23519500, 16'h8000, 8'hA},
		'{12'h203, 0, 4000000, 16'h0000, 8'h8},
		'{12'h203, 0, 16000000, 16'h5100, 8'h8},
		'{12'h203, 0, 20000000, 16'h6C00, 8'h8},
		'{12'h203, 0, 1185000, 16'hED00, 8'h8},
		'{12'h203, 0, 1000000, 16'h8000, 8'hA},
		'{12'h202, 0, -3518518, 16'hED00, 8'h8},
		'{12'h003, 0, 30000000, 16'h7FFF, 8'h8},
		'{12'h000, 0, 10000000, 16'h0000, 8'h8},
		'{12'h304, 1, 0, 16'h7FFF, 8'h9},
		'{12'h103, 1, 0, 16'h7FFF, 8'h9},
		'{12'h204, 1, 0, 16'h8000, 8'hA},
		'{12'h004, 1, 0, 16'h8000, 8'h8}};

	// 100 MHz clock
	always #5 clk = ~clk;

	cive_encoder i_cive_encoder (.clk_in(clk), .reset_n_in(rst_n), .sample_in(smp),
		.wire_break_in(wbrk), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
		.paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .word_out(word), .word_valid_out(wvalid), .irq_out(irq));

	cive_reader i_cive_reader (.clk_in(clk), .reset_n_in(rst_n), .word_in(word),
		.word_valid_in(wvalid), .last_word_out(last), .n_words_out(nw));

	// Compare and count
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic complete_run();
		$display("errors %0d compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// One APB transfer, held until pready is seen
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	// One converter sample and its word
	task automatic meas(input logic signed [31:0] na, input logic [15:0] exp);
		@(posedge clk);
		smp <= {1'b1, na};
		@(posedge clk);
		smp.valid <= 1'b0;
		@(negedge clk);
		check("valid", wvalid, 1'b1);
		check("word", word, exp);
		@(posedge clk);
		#1 check("reader", last, exp);
	endtask

	// Reset values, unmapped and read-only places
	task automatic t_regs();
		for (int a = 0; a < 16; a += 4)
		begin
			apb(1'b0, a[11:0], 32'h0);
			check("reset", rd, 32'h0);
			check("err", err, 1'b0);
		end
		check("ready", pready, 1'b1);
		apb(1'b1, 12'h010, 32'hFFFFFFFF);
		check("err", err, 1'b1);
		apb(1'b0, 12'h010, 32'h0);
		check("unmapped", {rd[31:1], err}, 32'h1);
		apb(1'b1, `CIVE_ADDR_CTRL, 32'hFFFFFFFF);
		apb(1'b0, `CIVE_ADDR_CTRL, 32'h0);
		check("ctrl", rd, 32'h3FF);
		apb(1'b1, `CIVE_ADDR_DATA, 32'h1234);
		apb(1'b0, `CIVE_ADDR_DATA, 32'h0);
		check("data", rd, 32'h0);
	endtask

	// Every band, range code and diagnostic setting
	task automatic t_table();
		for (int i = 0; i < 20; i++)
		begin
			apb(1'b1, `CIVE_ADDR_CTRL, tv[i][0]);
			wbrk <= tv[i][1][0];
			repeat (3) @(posedge clk);
			meas(tv[i][2], tv[i][3][15:0]);
			apb(1'b0, `CIVE_ADDR_STATUS, 32'h0);
			if (tv[i][4] != 8'hFF)
				check("status", rd, tv[i][4]);
			apb(1'b1, `CIVE_ADDR_STATUS, 32'hF);
		end
		wbrk <= 1'b0;
		apb(1'b0, `CIVE_ADDR_DATA, 32'h0);
		check("data", rd, 32'h8000);
	endtask

	// Interrupt raised, cleared and masked
	task automatic t_irq();
		apb(1'b1, `CIVE_ADDR_MASK, 32'h2);
		apb(1'b1, `CIVE_ADDR_CTRL, 32'h204);
		meas(-30000000, 16'h8000);
		check("irq", irq, 1'b1);
		apb(1'b1, `CIVE_ADDR_STATUS, 32'h2);
		#1 check("irq", irq, 1'b0);
		apb(1'b1, `CIVE_ADDR_MASK, 32'h4);
		meas(-30000000, 16'h8000);
		check("irq", irq, 1'b0);
		apb(1'b1, `CIVE_ADDR_MASK, 32'h1);
		apb(1'b1, `CIVE_ADDR_CTRL, 32'h304);
		wbrk <= 1'b1;
		repeat (3) @(posedge clk);
		meas(0, 16'h7FFF);
		check("irq", irq, 1'b1);
		check("words", nw, 32'h00000017);
		@(posedge clk);
		wbrk <= 1'b0;
	endtask

	// Hang guard
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			errors++;
			complete_run();
		end
	end

	// Main sequence
	initial
	begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_table();
		t_irq();
		complete_run();
	end
endmodule // tb_current_input_value_encoder
`default_nettype wire
